// File: rtl/uerr_mask.sv
// USB error flags, their enables, summary error flag and interrupt output
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module uerr_mask
  import uerr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic stuff_err_i,
  input wire logic field_size_err_i,
  input wire logic data_check_fail_i,
  input wire logic token_check_fail_i,
  input wire logic packet_id_fail_i,
  input wire logic eop_i,
  input wire logic bus_idle_i,
  input wire logic bit_tick_i,
  output logic irq_o
);

  logic [7:0] usb_error_enables;
  logic [7:0] usb_error_flags;
  logic [7:0] usb_irq_flags;
  logic [7:0] usb_irq_enables;
  logic [7:0] err_events;
  logic timeout_event;
  logic [4:0] idle_bits;
  logic idle_armed;
  logic summary_error_flag;
  logic wr_err_flags;
  logic wr_irq_flags;

  // Idle bit times after EOP; counting stops once the time-out fires
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      idle_bits <= 5'h00;
      idle_armed <= 1'b0;
    end else if (eop_i) begin
      idle_bits <= 5'h00;
      idle_armed <= 1'b1;
    end else if (!bus_idle_i) begin
      idle_armed <= 1'b0;
    end else if (idle_armed && bit_tick_i) begin
      if (idle_bits == UERR_TURNAROUND_BIT_TIMES) begin
        idle_armed <= 1'b0;
      end else begin
        idle_bits <= idle_bits + 5'h01;
      end
    end
  end

  // Seventeenth idle bit time is "more than 16"
  assign timeout_event = idle_armed && bus_idle_i && bit_tick_i && !eop_i &&
                         (idle_bits == UERR_TURNAROUND_BIT_TIMES);

  always_comb begin
    err_events = 8'h00;
    err_events[UERR_STUFF_BIT] = stuff_err_i;
    err_events[UERR_TIMEOUT_BIT] = timeout_event;
    err_events[UERR_SIZE_BIT] = field_size_err_i;
    err_events[UERR_DATA_CRC_BIT] = data_check_fail_i;
    err_events[UERR_TOKEN_CRC_BIT] = token_check_fail_i;
    err_events[UERR_PID_BIT] = packet_id_fail_i;
  end

  assign wr_err_flags = wr_i && (addr_i == UERR_ADDR_ERR_FLAGS);
  assign wr_irq_flags = wr_i && (addr_i == UERR_ADDR_IRQ_FLAGS);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      usb_error_enables <= UERR_ERR_ENABLES_RST;
    end else if (wr_i && addr_i == UERR_ADDR_ERR_ENABLES) begin
      usb_error_enables <= wdata_i & UERR_ERR_IMPL_MASK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      usb_irq_enables <= UERR_IRQ_ENABLES_RST;
    end else if (wr_i && addr_i == UERR_ADDR_IRQ_ENABLES) begin
      usb_irq_enables <= wdata_i & UERR_IRQ_IMPL_MASK;
    end
  end

  // One sticky flag per implemented bit (bits 6:5 held at zero); a new event in the clearing cycle wins
  for (genvar b = 0; b < 8; b++) begin : g_err_flag
    if (UERR_ERR_IMPL_MASK[b]) begin : g_impl
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          usb_error_flags[b] <= UERR_ERR_FLAGS_RST[b];
        end else if (err_events[b]) begin
          usb_error_flags[b] <= 1'b1;
        end else if (wr_err_flags && wdata_i[b]) begin
          usb_error_flags[b] <= 1'b0;
        end
      end

      a_flag_set_bit: assert property (@(posedge core_clk_i) disable iff (reset_i)
        err_events[b] |=>
        usb_error_flags[b])
        else $error("error event did not set its flag");

      a_flag_clear_bit: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (!err_events[b] && wr_err_flags && wdata_i[b]) |=>
        !usb_error_flags[b])
        else $error("write of one did not clear the flag");

      a_flag_hold_bit: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (!err_events[b] && !(wr_err_flags && wdata_i[b])) |=>
        $stable(usb_error_flags[b]))
        else $error("error flag changed without cause");

      a_flag_enable_sum: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (usb_error_flags[b] && usb_error_enables[b]) |=>
        usb_irq_flags[UERR_SUMMARY_BIT])
        else $error("enabled flag did not raise summary");
    end else begin : g_unused
      always_ff @(posedge core_clk_i) begin
        usb_error_flags[b] <= 1'b0;
      end
    end
  end

  // Gated OR recomputed every cycle from flags and enables
  assign summary_error_flag = |(usb_error_flags & usb_error_enables);

  // Summary bit is read-only status; other bits are software-clearable
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      usb_irq_flags <= UERR_IRQ_FLAGS_RST;
    end else begin
      usb_irq_flags <= (usb_irq_flags & ~(wr_irq_flags ? wdata_i : 8'h00)) & UERR_IRQ_IMPL_MASK;
      usb_irq_flags[UERR_SUMMARY_BIT] <= summary_error_flag;
    end
  end

  assign irq_o = |(usb_irq_flags & usb_irq_enables);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == UERR_ADDR_IRQ_FLAGS) begin
        rdata_o <= usb_irq_flags;
      end else if (addr_i == UERR_ADDR_IRQ_ENABLES) begin
        rdata_o <= usb_irq_enables;
      end else if (addr_i == UERR_ADDR_ERR_FLAGS) begin
        rdata_o <= usb_error_flags;
      end else begin
        rdata_o <= usb_error_enables;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Reset values and register storage
  a_enable_reserved_zero: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (usb_error_enables[6:5] == 2'b00) &&
    (usb_error_flags[6:5] == 2'b00))
    else $error("reserved error bits not zero");

  a_enables_reset_clear: assert property (@(posedge core_clk_i)
    ($past(reset_i) && !reset_i) |->
    usb_error_enables == 8'h00)
    else $error("error enables not cleared by reset");

  a_flags_reset_clear: assert property (@(posedge core_clk_i)
    ($past(reset_i) && !reset_i) |->
    usb_error_flags == 8'h00)
    else $error("error flags not cleared by reset");

  a_rdata_reset_clear: assert property (@(posedge core_clk_i)
    ($past(reset_i) && !reset_i) |->
    rdata_o == 8'h00)
    else $error("read data not cleared by reset");

  a_irq_reset_quiet: assert property (@(posedge core_clk_i)
    ($past(reset_i) && !reset_i) |->
    !irq_o)
    else $error("interrupt high after reset");

  a_enables_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (wr_i && addr_i == UERR_ADDR_ERR_ENABLES) |=>
    usb_error_enables == ($past(wdata_i) & UERR_ERR_IMPL_MASK))
    else $error("error enables write lost");

  a_enables_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !(wr_i && addr_i == UERR_ADDR_ERR_ENABLES) |=>
    $stable(usb_error_enables))
    else $error("error enables changed without a write");

  a_irq_enables_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (wr_i && addr_i == UERR_ADDR_IRQ_ENABLES) |=>
    usb_irq_enables == ($past(wdata_i) & UERR_IRQ_IMPL_MASK))
    else $error("interrupt enables write lost");

  a_irq_enables_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !(wr_i && addr_i == UERR_ADDR_IRQ_ENABLES) |=>
    $stable(usb_irq_enables))
    else $error("interrupt enables changed without a write");

  a_irq_reserved_zero: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (usb_irq_flags[7] == 1'b0) &&
    (usb_irq_enables[7] == 1'b0))
    else $error("reserved interrupt bit not zero");

  // Read port: data stands one cycle after the strobe, zero otherwise
  a_read_idle_zero: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !$past(rd_i) |->
    rdata_o == 8'h00)
    else $error("read data not zero between reads");

  a_read_err_enables: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (rd_i && addr_i == UERR_ADDR_ERR_ENABLES) |=>
    rdata_o == $past(usb_error_enables))
    else $error("error enables read wrong");

  a_read_err_flags: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (rd_i && addr_i == UERR_ADDR_ERR_FLAGS) |=>
    rdata_o == $past(usb_error_flags))
    else $error("error flags read wrong");

  a_read_irq_flags: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (rd_i && addr_i == UERR_ADDR_IRQ_FLAGS) |=>
    rdata_o == $past(usb_irq_flags))
    else $error("interrupt flags read wrong");

  a_read_irq_enables: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (rd_i && addr_i == UERR_ADDR_IRQ_ENABLES) |=>
    rdata_o == $past(usb_irq_enables))
    else $error("interrupt enables read wrong");

  // Summary flag and interrupt output
  a_summary_tracks_mask: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 usb_irq_flags[UERR_SUMMARY_BIT] ==
    $past(|(usb_error_flags & usb_error_enables)))
    else $error("summary flag does not track masked errors");

  a_masked_no_summary: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (usb_error_enables == 8'h00) ##1 (usb_error_enables == 8'h00) |->
    !usb_irq_flags[UERR_SUMMARY_BIT])
    else $error("summary set with all errors masked");

  sequence s_summary_write_attempt;
    wr_irq_flags && wdata_i[UERR_SUMMARY_BIT];
  endsequence
  a_summary_not_cleared: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_summary_write_attempt ##0 ((usb_error_flags & usb_error_enables) != 8'h00) |=>
    usb_irq_flags[UERR_SUMMARY_BIT])
    else $error("software cleared the summary flag");

  a_summary_not_set: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (wr_irq_flags && ((usb_error_flags & usb_error_enables) == 8'h00)) |=>
    !usb_irq_flags[UERR_SUMMARY_BIT])
    else $error("software set the summary flag");

  sequence s_nothing_enabled;
    (usb_error_flags & usb_error_enables) == 8'h00;
  endsequence
  a_summary_drops: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_nothing_enabled |=>
    !usb_irq_flags[UERR_SUMMARY_BIT])
    else $error("summary held without an enabled flag");

  sequence s_stuff_enabled_err;
    usb_error_enables[UERR_STUFF_BIT] && stuff_err_i;
  endsequence
  a_stuff_raises_sum: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_stuff_enabled_err ##1 usb_error_enables[UERR_STUFF_BIT] |->
    ##1 usb_irq_flags[UERR_SUMMARY_BIT])
    else $error("enabled stuff error did not raise summary");

  a_flag_set_wins: assert property (@(posedge core_clk_i) disable iff (reset_i)
    packet_id_fail_i |=>
    usb_error_flags[UERR_PID_BIT])
    else $error("error event lost");

  a_irq_needs_enable: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (usb_irq_flags[UERR_SUMMARY_BIT] && usb_irq_enables[UERR_SUMMARY_BIT]) |->
    irq_o)
    else $error("summary interrupt not forwarded");

  a_irq_blocked: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (usb_irq_enables == 8'h00) |->
    !irq_o)
    else $error("interrupt raised with all sources masked");

  // Turnaround timing
  sequence s_idle_after_eop;
    eop_i ##1 (bus_idle_i && !eop_i) [*8];
  endsequence
  a_no_early_timeout: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_idle_after_eop |->
    !timeout_event)
    else $error("time-out raised too early");

  sequence s_eop_seen;
    eop_i;
  endsequence
  a_eop_arms: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_eop_seen |=>
    idle_armed && (idle_bits == 5'h00))
    else $error("end of packet did not restart timing");

  a_busy_disarms: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!bus_idle_i && !eop_i) |=>
    !idle_armed)
    else $error("bus activity did not cancel timing");

  a_tick_counts: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (idle_armed && bus_idle_i && bit_tick_i && !eop_i && (idle_bits != UERR_TURNAROUND_BIT_TIMES)) |=>
    idle_bits == $past(idle_bits) + 5'h01)
    else $error("idle bit time not counted");

  a_count_limit: assert property (@(posedge core_clk_i) disable iff (reset_i)
    idle_bits <=
    UERR_TURNAROUND_BIT_TIMES)
    else $error("idle count past its limit");

  a_timeout_once: assert property (@(posedge core_clk_i) disable iff (reset_i)
    timeout_event |=>
    !idle_armed)
    else $error("time-out timing still armed");

endmodule : uerr_mask

`default_nettype wire

// File: rtl/uerr_pkg.sv
// Register map, field positions and timing constants of the USB error interrupt block
package uerr_pkg;
  localparam logic [1:0] UERR_ADDR_IRQ_FLAGS = 2'h0;
  localparam logic [1:0] UERR_ADDR_IRQ_ENABLES = 2'h1;
  localparam logic [1:0] UERR_ADDR_ERR_FLAGS = 2'h2;
  localparam logic [1:0] UERR_ADDR_ERR_ENABLES = 2'h3;
  localparam int UERR_STUFF_BIT = 7;
  localparam int UERR_TIMEOUT_BIT = 4;
  localparam int UERR_SIZE_BIT = 3;
  localparam int UERR_DATA_CRC_BIT = 2;
  localparam int UERR_TOKEN_CRC_BIT = 1;
  localparam int UERR_PID_BIT = 0;
  localparam int UERR_SUMMARY_BIT = 1;
  localparam logic [7:0] UERR_ERR_IMPL_MASK = 8'h9f;
  localparam logic [7:0] UERR_IRQ_IMPL_MASK = 8'h7f;
  localparam logic [7:0] UERR_ERR_ENABLES_RST = 8'h00;
  localparam logic [7:0] UERR_ERR_FLAGS_RST = 8'h00;
  localparam logic [7:0] UERR_IRQ_FLAGS_RST = 8'h00;
  localparam logic [7:0] UERR_IRQ_ENABLES_RST = 8'h00;
  localparam logic [4:0] UERR_TURNAROUND_BIT_TIMES = 5'h10;
endpackage : uerr_pkg

// File: sim/uerr_host_model.sv
// Far-side model: end of packet and idle bit times from the serial engine
`timescale 1ns/1ps
`default_nettype none
module uerr_host_model (
  input wire logic core_clk_i,
  input wire logic go_i,
  input wire logic [5:0] ticks_i,
  input wire logic busy_i,
  output logic eop_o,
  output logic bus_idle_o,
  output logic bit_tick_o
);
  logic [5:0] left = 6'h00;
  initial eop_o = 1'b0;
  initial bit_tick_o = 1'b0;
  // Bus idle unless the bench holds it busy; one bit time per clock
  assign bus_idle_o = !busy_i;
  always @(posedge core_clk_i) begin
    eop_o <= go_i;
    bit_tick_o <= (left != 6'h00);
    if (go_i)
      left <= ticks_i;
    else if (left != 6'h00)
      left <= left - 6'h01;
  end
endmodule : uerr_host_model
`default_nettype wire

// File: sim/uerr_mask_bench.sv
// Self-checking bench of the USB error masking block
`timescale 1ns/1ps
`default_nettype none
module uerr_mask_bench;
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, go = 1'b0, busy = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, ev = 8'h00, rdata;
  logic [5:0] ticks = 6'h00;
  logic eop, idle, tick, irq;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  // Rows: enables written, events pulsed, enables read back, interrupt flags read back
  logic [7:0] rows [8][4] = '{'{8'h80, 8'h80, 8'h80, 8'h02}, '{8'h08, 8'h08, 8'h08, 8'h02},
    '{8'h04, 8'h04, 8'h04, 8'h02}, '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h01, 8'h01, 8'h01, 8'h02},
    '{8'h7f, 8'h80, 8'h1f, 8'h00}, '{8'hf7, 8'h08, 8'h97, 8'h00}, '{8'hff, 8'h00, 8'h9f, 8'h00}};
  uerr_mask uerr_mask_i (.core_clk_i(clk), .reset_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .stuff_err_i(ev[7]), .field_size_err_i(ev[3]),
    .data_check_fail_i(ev[2]), .token_check_fail_i(ev[1]), .packet_id_fail_i(ev[0]),
    .eop_i(eop), .bus_idle_i(idle), .bit_tick_i(tick), .irq_o(irq));
  uerr_host_model uerr_host_model_i (.core_clk_i(clk), .go_i(go), .ticks_i(ticks), .busy_i(busy),
    .eop_o(eop), .bus_idle_o(idle), .bit_tick_o(tick));
  always #10 clk = ~clk;
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 q = rdata;
  endtask : rd
  task automatic pulse(input logic [7:0] e, input logic [5:0] n, input logic g);
    @(posedge clk);
    ev <= e;
    ticks <= n;
    go <= g;
    @(posedge clk);
    ev <= 8'h00;
    go <= 1'b0;
    repeat (25) @(posedge clk);
  endtask : pulse
  initial begin
    logic [7:0] q;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), q);
      chk("reset value", q, 8'h00);
    end
    wr(2'h0, 8'h02);
    rd(2'h0, q);
    chk("summary write", q, 8'h00);
    wr(2'h1, 8'h02);
    foreach (rows[i]) begin
      wr(2'h3, rows[i][0]);
      pulse(rows[i][1], 6'h00, 1'b0);
      rd(2'h3, q);
      chk("enables", q, rows[i][2]);
      rd(2'h2, q);
      chk("error flags", q, rows[i][1]);
      rd(2'h0, q);
      chk("summary", q, rows[i][3]);
      chk("irq", {7'h00, irq}, {7'h00, rows[i][3][1]});
      wr(2'h2, 8'hff);
    end
    // Event and clearing write in the same cycle
    @(posedge clk);
    addr <= 2'h2;
    wdata <= 8'h01;
    wr_s <= 1'b1;
    ev <= 8'h01;
    @(posedge clk);
    wr_s <= 1'b0;
    ev <= 8'h00;
    rd(2'h2, q);
    chk("set beats clear", q, 8'h01);
    wr(2'h2, 8'h01);
    wr(2'h3, 8'h10);
    pulse(8'h00, 6'h10, 1'b1);
    rd(2'h2, q);
    chk("timeout at 16", q, 8'h00);
    pulse(8'h00, 6'h11, 1'b1);
    rd(2'h2, q);
    chk("timeout at 17", q, 8'h10);
    chk("irq on", {7'h00, irq}, 8'h01);
    wr(2'h1, 8'h00);
    rd(2'h0, q);
    chk("irq masked", {7'h00, irq}, 8'h00);
    chk("summary held", q, 8'h02);
    wr(2'h2, 8'h10);
    rd(2'h0, q);
    chk("summary cleared", q, 8'h00);
    busy <= 1'b1;
    pulse(8'h00, 6'h11, 1'b1);
    busy <= 1'b0;
    rd(2'h2, q);
    chk("busy cancels timeout", q, 8'h00);
    wr(2'h3, 8'hff);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(2'h3, q);
    chk("enables after reset", q, 8'h00);
    rd(2'h0, q);
    chk("irq flags after reset", q, 8'h00);
    wrap_up();
  end
endmodule : uerr_mask_bench
`default_nettype wire
